/* hdl/bss_supervisor.sv */
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps

module bss_supervisor
  import bss_pkg::*;
#(
  parameter int BAT_PERIOD = bss_pkg::BAT_PERIOD_CYC,
  parameter int RESET_DELAY = bss_pkg::RESET_DELAY_CYC
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // comparator results, asynchronous
  input wire logic vdd_present,
  input wire logic vdd_above_sw_falling,
  input wire logic vdd_above_sw_rising,
  input wire logic vdd_above_battery,
  input wire logic vout_above_reset,
  input wire logic battery_present,
  input wire logic battery_above_good,
  input wire logic powerfail_above,
  input wire logic powerfail_above_hyst,
  // user pins
  input wire logic manual_reset_n,
  input wire logic force_backup,
  input wire logic chip_enable_in,
  input wire logic powerfail_flag_in,
  // supply control and status
  output logic battery_path_active,
  output logic battery_connect,
  output logic battery_load_en,
  output logic battery_good_flag,
  output logic reset_out_n,
  // power-fail flag pin
  output logic powerfail_flag_n,
  output logic powerfail_flag_oe_n,
  // chip-enable gate
  output logic chip_enable_out,
  output logic chip_enable_pullup,
  output logic chip_enable_in_hiz
);
  import bss_pkg::*;

  // ***************************************************************
  // input synchronisers
  // ***************************************************************
  bss_sync_if #(.W(SYNC_W)) sif();
  logic [SYNC_W-1:0] in_s;

  assign sif.raw = {battery_present, powerfail_flag_in, chip_enable_in, force_backup,
                    manual_reset_n, powerfail_above_hyst, powerfail_above, battery_above_good,
                    vout_above_reset, vdd_above_battery, vdd_above_sw_rising,
                    vdd_above_sw_falling, vdd_present};
  assign in_s = sif.clean;

  bss_sync #(.W(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .port(sif)
  );

  // ***************************************************************
  // register file
  // ***************************************************************
  logic [1:0] ctrl, next_ctrl;
  logic [31:0] rdata, next_rdata;
  logic err, next_err;
  logic setup;
  logic access;
  logic [31:0] status_word;

  // zero wait states: read data is latched in the setup cycle, a write lands in the access cycle
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign pready = 1'b1;
  assign prdata = rdata;
  assign pslverr = err;

  // ***************************************************************
  // core state
  // ***************************************************************
  bss_seal_t seal, next_seal;
  logic bat_sel, next_bat_sel;
  logic rst_n, next_rst_n;
  logic [CNT_W-1:0] rst_cnt, next_rst_cnt;
  logic ce_blk, next_ce_blk;
  logic [CNT_W-1:0] ce_cnt, next_ce_cnt;
  logic ce_q, next_ce_q;
  logic [CNT_W-1:0] per_cnt, next_per_cnt;
  logic [CNT_W-1:0] on_cnt, next_on_cnt;
  logic load, next_load;
  logic good, next_good;
  logic pf, next_pf;
  logic rst_cond, force_any, release_edge;

  assign status_word = {22'h000000, seal, in_s[IX_VOUT_OK], in_s[IX_VDD_PRESENT],
                        load, pf, ce_blk, good, rst_n, bat_sel};

  // reset stays asserted under manual reset, low supply, or sealed without supply
  assign rst_cond = !in_s[IX_MR_N] || !in_s[IX_VOUT_OK]
                    || (seal == SEAL_ON && !in_s[IX_VDD_PRESENT]);
  assign force_any = in_s[IX_FORCE] || ctrl[CTRL_FORCE_BIT];
  assign release_edge = !rst_n && next_rst_n;

  // register access decode
  always_comb begin
    next_ctrl = ctrl;
    next_rdata = rdata;
    next_err = err;
    if (setup) begin
      next_err = 1'b0;
      next_rdata = 32'h00000000;
      if (paddr == OFF_CTRL) begin
        next_rdata = pwrite ? 32'h00000000 : {30'h00000000, ctrl};
      end else if (paddr == OFF_STATUS) begin
        next_rdata = pwrite ? 32'h00000000 : status_word;
      end else begin
        next_err = 1'b1;
      end
    end
    // a write takes effect only when the transfer completes, never in its setup cycle
    if (access && pwrite && paddr == OFF_CTRL) begin
      next_ctrl = pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST;
      rdata <= 32'h00000000;
      err <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      rdata <= next_rdata;
      err <= next_err;
    end
  end

  // supply, reset, seal, chip-enable and battery check next values
  always_comb begin
    next_seal = seal;
    next_bat_sel = bat_sel;
    next_rst_n = rst_n;
    next_rst_cnt = rst_cnt;
    next_ce_blk = ce_blk;
    next_ce_cnt = ce_cnt;
    next_ce_q = in_s[IX_CE_IN];
    next_per_cnt = per_cnt;
    next_on_cnt = on_cnt;
    next_load = load;
    next_good = good;
    next_pf = pf;

    // reset delay restarts whenever a reset cause is seen
    if (rst_cond) begin
      next_rst_n = 1'b0;
      next_rst_cnt = '0;
    end else if (!rst_n) begin
      if (rst_cnt >= CNT_W'(RESET_DELAY - 1)) begin
        next_rst_n = 1'b1;
      end else begin
        next_rst_cnt = rst_cnt + 1'b1;
      end
    end

    // freshness seal sequence
    case (seal)
      SEAL_OFF: begin
        if (in_s[IX_VDD_PRESENT] && in_s[IX_BAT_PRESENT] && !in_s[IX_PF_PIN]
            && in_s[IX_PF_ABOVE] && !in_s[IX_MR_N] && in_s[IX_VOUT_OK]) begin
          next_seal = SEAL_ARMED;
        end
      end
      SEAL_ARMED: begin
        if (!in_s[IX_VDD_PRESENT]) begin
          next_seal = SEAL_ON;
        end else if (in_s[IX_PF_PIN] || in_s[IX_MR_N]) begin
          next_seal = SEAL_OFF;
        end
      end
      SEAL_ON: begin
        if (release_edge && in_s[IX_VDD_PRESENT]) begin
          next_seal = SEAL_OFF;
        end
      end
      default: begin
        next_seal = SEAL_OFF;
      end
    endcase

    // source selection; a sealed battery is never switched in
    if (seal == SEAL_ON) begin
      next_bat_sel = 1'b0;
    end else if (!bat_sel) begin
      if (force_any || (!in_s[IX_VDD_GT_BAT] && !in_s[IX_VDD_SW_FALL])) begin
        next_bat_sel = 1'b1;
      end
    end else if (!force_any && (in_s[IX_VDD_GT_BAT] || in_s[IX_VDD_SW_RISE])) begin
      next_bat_sel = 1'b0;
    end

    // chip-enable gate: hold off blocking so a write in flight can finish
    if (rst_n) begin
      next_ce_blk = 1'b0;
      next_ce_cnt = '0;
    end else if (!ce_blk) begin
      if (in_s[IX_CE_IN] || ce_cnt >= CNT_W'(CE_HOLD_CYC - 1)) begin
        next_ce_blk = 1'b1;
      end else begin
        next_ce_cnt = ce_cnt + 1'b1;
      end
    end

    // power-fail comparator with hysteresis
    if (!in_s[IX_PF_ABOVE]) begin
      next_pf = 1'b0;
    end else if (in_s[IX_PF_ABOVE_HYST]) begin
      next_pf = 1'b1;
    end

    // periodic battery check only while out of reset and not sealed
    if (!rst_n || seal == SEAL_ON || ctrl[CTRL_CHECK_OFF_BIT]) begin
      next_per_cnt = '0;
      next_on_cnt = '0;
      next_load = 1'b0;
    end else if (load) begin
      next_per_cnt = per_cnt + 1'b1;
      if (on_cnt >= CNT_W'(BAT_ON_CYC - 1)) begin
        next_load = 1'b0;
        next_good = in_s[IX_BAT_GOOD];
      end else begin
        next_on_cnt = on_cnt + 1'b1;
      end
    end else if (per_cnt >= CNT_W'(BAT_PERIOD - 1)) begin
      next_per_cnt = '0;
      next_on_cnt = '0;
      next_load = 1'b1;
    end else begin
      next_per_cnt = per_cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seal <= SEAL_OFF;
      bat_sel <= 1'b0;
      rst_n <= 1'b0;
      rst_cnt <= '0;
      ce_blk <= 1'b1;
      ce_cnt <= '0;
      ce_q <= 1'b1;
      per_cnt <= '0;
      on_cnt <= '0;
      load <= 1'b0;
      good <= BAT_GOOD_RST;
      pf <= PF_FLAG_RST;
    end else begin
      seal <= next_seal;
      bat_sel <= next_bat_sel;
      rst_n <= next_rst_n;
      rst_cnt <= next_rst_cnt;
      ce_blk <= next_ce_blk;
      ce_cnt <= next_ce_cnt;
      ce_q <= next_ce_q;
      per_cnt <= next_per_cnt;
      on_cnt <= next_on_cnt;
      load <= next_load;
      good <= next_good;
      pf <= next_pf;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign battery_path_active = bat_sel;
  assign battery_connect = (seal != SEAL_ON);
  assign battery_load_en = load;
  assign battery_good_flag = good;
  assign reset_out_n = rst_n;
  assign powerfail_flag_n = pf;
  // the flag pin is released while sealed so it may be left floating
  assign powerfail_flag_oe_n = (seal == SEAL_ON);
  // blocked path forces the output high through the pull-up
  assign chip_enable_out = ce_blk ? 1'b1 : ce_q;
  assign chip_enable_pullup = ce_blk;
  assign chip_enable_in_hiz = ce_blk;

endmodule

/* hdl/bss_pkg.sv */
package bss_pkg;

  // ***************************************************************
  // timebase
  // ***************************************************************
  localparam int CLK_MHZ = 50;
  localparam int BAT_PERIOD_MS = 200;
  localparam int BAT_ON_US = 25;
  localparam int CE_HOLD_US = 15;
  // exact products of whole microseconds, never below one cycle
  localparam int BAT_ON_CYC = (BAT_ON_US * CLK_MHZ < 1) ? 1 : BAT_ON_US * CLK_MHZ;
  localparam int CE_HOLD_CYC = (CE_HOLD_US * CLK_MHZ < 1) ? 1 : CE_HOLD_US * CLK_MHZ;
  localparam int BAT_PERIOD_CYC = BAT_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int RESET_DELAY_CYC = 1000;
  localparam int CNT_W = 32;

  // ***************************************************************
  // synchronised input bit positions
  // ***************************************************************
  localparam int SYNC_W = 13;
  localparam int IX_VDD_PRESENT = 0;
  localparam int IX_VDD_SW_FALL = 1;
  localparam int IX_VDD_SW_RISE = 2;
  localparam int IX_VDD_GT_BAT = 3;
  localparam int IX_VOUT_OK = 4;
  localparam int IX_BAT_GOOD = 5;
  localparam int IX_PF_ABOVE = 6;
  localparam int IX_PF_ABOVE_HYST = 7;
  localparam int IX_MR_N = 8;
  localparam int IX_FORCE = 9;
  localparam int IX_CE_IN = 10;
  localparam int IX_PF_PIN = 11;
  localparam int IX_BAT_PRESENT = 12;
  localparam logic [SYNC_W-1:0] SYNC_RST = 13'h0000;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam int CTRL_FORCE_BIT = 0;
  localparam int CTRL_CHECK_OFF_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic BAT_GOOD_RST = 1'b1;
  localparam logic PF_FLAG_RST = 1'b1;

  // ***************************************************************
  // freshness-seal states
  // ***************************************************************
  typedef enum logic [1:0] {
    SEAL_OFF = 2'b00,
    SEAL_ARMED = 2'b01,
    SEAL_ON = 2'b10
  } bss_seal_t;

endpackage

/* hdl/bss_sync_if.sv */
`timescale 1ns/1ps
interface bss_sync_if #(parameter int W = 13);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface

/* hdl/bss_sync.sv */
`timescale 1ns/1ps
module bss_sync #(
  parameter int W = 13,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw pins in, filtered levels out
  bss_sync_if.sync port
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1, s2, s3, clean;
      logic next_clean;

      // a change counts only once stage two and three agree
      always_comb begin
        next_clean = (s2 == s3) ? s3 : clean;
      end

      // stage one feeds stage two only
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1 <= RST_VAL[i];
          s2 <= RST_VAL[i];
          s3 <= RST_VAL[i];
          clean <= RST_VAL[i];
        end else begin
          s1 <= port.raw[i];
          s2 <= s1;
          s3 <= s2;
          clean <= next_clean;
        end
      end

      assign port.clean[i] = clean;
    end
  endgenerate

endmodule

/* verification/bss_supervisor_sva.sv */
`timescale 1ns/1ps
module bss_supervisor_sva (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // comparator levels and pins
  input wire logic vdd_above_sw_falling,
  input wire logic vdd_above_battery,
  input wire logic powerfail_above,
  input wire logic powerfail_above_hyst,
  input wire logic chip_enable_in,
  // outputs watched
  input wire logic battery_path_active,
  input wire logic battery_connect,
  input wire logic battery_load_en,
  input wire logic reset_out_n,
  input wire logic powerfail_flag_n,
  input wire logic powerfail_flag_oe_n,
  input wire logic chip_enable_out,
  input wire logic chip_enable_pullup,
  input wire logic chip_enable_in_hiz
);
  import bss_pkg::*;
  // ***************************************************************
  // checks
  // ***************************************************************
  int on_cnt;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // load window length; cleared when closed so a cut window shows short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_cnt <= 0;
    end else begin
      on_cnt <= battery_load_en ? on_cnt + 1 : 0;
    end
  end
  AST_CE_PULL: assert property (chip_enable_pullup |-> chip_enable_out && chip_enable_in_hiz)
    else $error("blocked path not pulled high");
  AST_CE_FAST: assert property ($fell(reset_out_n) && chip_enable_in |-> ##[0:6] chip_enable_pullup)
    else $error("path not blocked at once with enable high");
  AST_CE_HOLD: assert property ($fell(reset_out_n) |-> ##[0:760] (chip_enable_pullup || reset_out_n))
    else $error("path not blocked within hold time");
  AST_CE_PASS: assert property ((reset_out_n && $stable(chip_enable_in))[*8]
    |-> !chip_enable_pullup && chip_enable_out == chip_enable_in)
    else $error("enable not passed through");
  AST_CE_RELEASE: assert property (reset_out_n [*2] |-> !chip_enable_pullup)
    else $error("pull-up kept after reset release");
  AST_LOAD_LEN: assert property ($fell(battery_load_en) && reset_out_n |-> on_cnt == BAT_ON_CYC)
    else $error("load window length wrong");
  AST_LOAD_START: assert property ($rose(battery_load_en) |-> reset_out_n && battery_connect)
    else $error("check started in reset or seal");
  AST_BAT_SEL: assert property (
    (!vdd_above_battery && !vdd_above_sw_falling && battery_connect)[*8]
    |-> battery_path_active)
    else $error("battery not selected");
  AST_PF_LOW: assert property (
    (!powerfail_above && !powerfail_above_hyst && !powerfail_flag_oe_n)[*8]
    |-> !powerfail_flag_n)
    else $error("flag not low below threshold");
  AST_PF_HIGH: assert property ((powerfail_above_hyst && !powerfail_flag_oe_n)[*8]
    |-> powerfail_flag_n)
    else $error("flag not high above hysteresis");
endmodule
bind bss_supervisor bss_supervisor_sva u_sva (.*);

/* verification/bss_host_model.sv */
`timescale 1ns/1ps
module bss_host_model (
  // host controls
  input wire logic pclk,
  input wire logic ce_drive,
  input wire logic flag_gnd,
  // flag pin from the supervisor
  input wire logic powerfail_flag_n,
  input wire logic powerfail_flag_oe_n,
  // levels seen by the supervisor
  output logic chip_enable_in,
  output logic powerfail_flag_in
);
  // line pulled up when undriven; a hard ground beats the driver
  assign powerfail_flag_in = flag_gnd ? 1'b0 : (powerfail_flag_oe_n ? 1'b1 : powerfail_flag_n);
  // select moves only just after an edge, like a host bus cycle
  initial chip_enable_in = 1'b1;
  always @(posedge pclk) begin
    chip_enable_in <= ce_drive;
  end
endmodule

/* verification/bss_supervisor_tb.sv */
`timescale 1ns/1ps
module bss_supervisor_tb;
  import bss_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic vdd_present, vdd_above_sw_falling, vdd_above_sw_rising, vdd_above_battery;
  logic vout_above_reset, battery_present, battery_above_good, powerfail_above;
  logic powerfail_above_hyst, manual_reset_n, force_backup, chip_enable_in;
  logic powerfail_flag_in, battery_path_active, battery_connect, battery_load_en;
  logic battery_good_flag, reset_out_n, powerfail_flag_n, powerfail_flag_oe_n;
  logic chip_enable_out, chip_enable_pullup, chip_enable_in_hiz, ce_drive, flag_gnd;
  int errors, checked, waited, hi;
  // {above battery, above falling, above rising, force, expected path}
  logic [4:0] sw_tab [8] = '{5'h01, 5'h09, 5'h0C, 5'h08, 5'h01, 5'h10, 5'h1F, 5'h1C};
  // watched outputs: 1 reset, 2 load, 3 blocked
  wire [3:0] obs = {chip_enable_pullup, battery_load_en, reset_out_n, 1'b0};
  // ***************************************************************
  // short counts keep the run small
  // ***************************************************************
  bss_supervisor #(.BAT_PERIOD(2000), .RESET_DELAY(50)) u_bss_supervisor (.*);
  bss_host_model u_bss_host_model (.*);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic tick(int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask
  // bounded wait for a watched output to reach a level
  task automatic wt(int i, logic v, int lim);
    waited = 0;
    while (obs[i] !== v) begin
      @(posedge pclk);
      waited++;
      if (waited > lim) begin
        errors++;
        give_verdict();
      end
    end
  endtask
  // one apb transfer; request held until pready seen high
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      give_verdict();
    end
    // idle edge so a following call never rewrites psel in this time step
    @(posedge pclk);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, force_backup, flag_gnd, paddr, pwdata} = '0;
    {vdd_present, vdd_above_sw_falling, vdd_above_sw_rising, vdd_above_battery} = '1;
    {vout_above_reset, battery_present, battery_above_good, powerfail_above} = '1;
    {powerfail_above_hyst, manual_reset_n, ce_drive} = '1;
    tick(20);
    chk({reset_out_n, chip_enable_pullup, chip_enable_in_hiz, battery_good_flag,
      powerfail_flag_n, battery_path_active}, 6'b011110);
    presetn <= 1'b1;
    wt(1, 1'b1, 200);
    chk(waited >= 50, 1);
    for (int k = 0; k < 2; k++) begin
      ce_drive <= k[0];
      tick(8);
      chk(chip_enable_out, k[0]);
    end
    apb(1'b0, OFF_STATUS, 0);
    chk(rd[3:1], 3'b011);
    apb(1'b0, 12'h008, 0);
    chk(rerr, 1);
    chk(rd, 0);
    apb(1'b1, OFF_CTRL, 32'h1);
    tick(8);
    chk(battery_path_active, 1);
    apb(1'b0, OFF_CTRL, 0);
    chk(rd, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h0);
    // battery check length and period, then a weak battery
    wt(2, 1'b1, 3000);
    wt(2, 1'b0, 2000);
    hi = waited;
    chk(hi, BAT_ON_CYC);
    battery_above_good <= 1'b0;
    wt(2, 1'b1, 3000);
    chk(hi + waited, 2000);
    wt(2, 1'b0, 2000);
    tick(4);
    chk(battery_good_flag, 0);
    battery_above_good <= 1'b1;
    // software stops the checks for over a period, then the schedule restarts from zero
    apb(1'b1, OFF_CTRL, 32'h2);
    hi = 0;
    repeat (2100) begin
      @(posedge pclk);
      hi += (battery_load_en !== 1'b0);
    end
    chk(hi, 0);
    apb(1'b1, OFF_CTRL, 32'h0);
    wt(2, 1'b1, 3000);
    chk(waited, 2000);
    // sense low, then above threshold only, then above hysteresis
    for (int k = 0; k < 3; k++) begin
      {powerfail_above, powerfail_above_hyst} <= 2'(k == 0 ? 0 : (k == 1 ? 2 : 3));
      tick(8);
      chk(powerfail_flag_n, k == 2);
    end
    foreach (sw_tab[k]) begin
      {vdd_above_battery, vdd_above_sw_falling, vdd_above_sw_rising, force_backup} <= sw_tab[k][4:1];
      tick(8);
      chk(battery_path_active, sw_tab[k][0]);
    end
    // reset with enable low: block waits for the hold time
    ce_drive <= 1'b0;
    manual_reset_n <= 1'b0;
    tick(100);
    chk({reset_out_n, chip_enable_pullup}, 2'b00);
    wt(3, 1'b1, 760);
    manual_reset_n <= 1'b1;
    ce_drive <= 1'b1;
    wt(1, 1'b1, 200);
    manual_reset_n <= 1'b0;
    tick(10);
    chk(chip_enable_pullup, 1);
    // seal entry: flag grounded, sense high, supply up, reset held, supply off
    flag_gnd <= 1'b1;
    tick(10);
    {vdd_present, vdd_above_sw_falling, vdd_above_sw_rising, vdd_above_battery} <= '0;
    vout_above_reset <= 1'b0;
    tick(10);
    flag_gnd <= 1'b0;
    manual_reset_n <= 1'b1;
    tick(2500);
    chk({battery_connect, battery_path_active, reset_out_n, battery_load_en}, 0);
    chk(powerfail_flag_oe_n, 1);
    {vdd_present, vdd_above_sw_falling, vdd_above_sw_rising, vdd_above_battery} <= '1;
    vout_above_reset <= 1'b1;
    wt(1, 1'b1, 200);
    tick(2);
    chk({battery_connect, powerfail_flag_oe_n}, 2'b10);
    // mid-run power-on reset returns the outputs to their idle levels
    presetn <= 1'b0;
    tick(3);
    chk({reset_out_n, chip_enable_pullup, battery_path_active, battery_connect}, 4'b0101);
    presetn <= 1'b1;
    wt(1, 1'b1, 200);
    chk(waited >= 50, 1);
    give_verdict();
  end
endmodule
